// *** shared/rem_mul_move_pkg.sv ***
// Constants shared by the remainder, multiply and move execution block
package rem_mul_move_pkg;

    // ------------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0]  OP_REM_BYTE_TWO_OP       = 8'hA7;
    localparam logic [7:0]  OP_REM_HALF_TWO_OP       = 8'hA6;
    localparam logic [7:0]  OP_REM_WORD_TWO_OP       = 8'hA4;
    localparam logic [7:0]  OP_REM_BYTE_THREE_OP     = 8'hE7;
    localparam logic [7:0]  OP_REM_HALF_THREE_OP     = 8'hE6;
    localparam logic [7:0]  OP_REM_WORD_THREE_OP     = 8'hE4;
    localparam logic [7:0]  OP_PRODUCT_BYTE_TWO_OP   = 8'hAB;
    localparam logic [7:0]  OP_PRODUCT_HALF_TWO_OP   = 8'hAA;
    localparam logic [7:0]  OP_PRODUCT_WORD_TWO_OP   = 8'hA8;
    localparam logic [7:0]  OP_PRODUCT_BYTE_THREE_OP = 8'hEB;
    localparam logic [7:0]  OP_PRODUCT_HALF_THREE_OP = 8'hEA;
    localparam logic [7:0]  OP_PRODUCT_WORD_THREE_OP = 8'hE8;
    localparam logic [7:0]  OP_COPY_BYTE             = 8'h87;
    localparam logic [7:0]  OP_COPY_HALF             = 8'h86;
    localparam logic [7:0]  OP_COPY_WORD             = 8'h84;
    localparam logic [7:0]  OP_LOAD_EFFECTIVE_ADDR   = 8'h04;
    localparam logic [15:0] OP_BLOCK_WORD_COPY       = 16'h3019;

    // ------------------------------------------------------------------
    // Operand sizes and block copy stepping
    // ------------------------------------------------------------------
    localparam logic [1:0]  SIZE_BYTE = 2'h0;
    localparam logic [1:0]  SIZE_HALF = 2'h1;
    localparam logic [1:0]  SIZE_WORD = 2'h2;
    localparam int          BYTE_BITS = 8;
    localparam int          HALF_BITS = 16;
    localparam int          WORD_BITS = 32;
    localparam logic [31:0] BLK_ADDR_STEP  = 32'h0000_0004;
    localparam logic [31:0] BLK_COUNT_STEP = 32'h0000_0001;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_BLK_CHK = 3'b001,
        ST_BLK_RD  = 3'b010,
        ST_BLK_WR  = 3'b011,
        ST_BLK_UPD = 3'b100
    } exec_state_t;

endpackage : rem_mul_move_pkg

// *** verilog/rem_mul_move_exec.sv ***
// Execution unit for remainder, multiply, move, move-address and block word copy
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Opcodes A7/A6/A4: destination becomes destination remainder source.
// - Opcodes E7/E6/E4: new destination gets second source remainder first source.
// - A zero divisor raises zero-divide and writes no result.
// - Remainder and multiply: N on negative, Z on zero, C cleared, V on overflow.
// - Truncated remainder or multiply result raises integer overflow.
// - Literal or immediate destination raises illegal operand.
// - Opcodes AB/AA/A8: destination becomes destination times source.
// - Opcodes EB/EA/E8: new destination gets product of both sources.
// - Moves copy source; N from top bit, Z on zero, C clear, V on truncation.
// - Converting moves sign-extend signed sources and zero-extend unsigned ones.
// - Word moves to or from the status word leave flags alone.
// - Opcode 04 stores the source's effective address; N,Z set, C,V cleared.
// - Move-address with literal, register or immediate source is illegal.
// - Block word copy is the operandless two-byte opcode 3019.
// - Source pointer, destination pointer and count are preset 32-bit words.
// - Each iteration copies a word, pointers advance by 4, count drops by 1.
// - Block copy ends at count zero and never changes the flags.
// - Interrupts are taken only between iterations, never during the update.
// - Pointers update only after the faultable access; a rerun resumes the copy.
module rem_mul_move_exec
    import rem_mul_move_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_start,
    input  wire logic [15:0] i_opcode,
    input  wire logic [31:0] i_op_a,
    input  wire logic [31:0] i_op_b,
    input  wire logic [31:0] i_src_ea,
    input  wire logic [1:0]  i_src_size,
    input  wire logic        i_src_signed,
    input  wire logic [1:0]  i_dst_size,
    input  wire logic        i_dst_signed,
    input  wire logic        i_dst_immediate,
    input  wire logic        i_src_no_ea,
    input  wire logic        i_src_is_psw,
    input  wire logic        i_dst_is_psw,
    input  wire logic [31:0] i_blk_src,
    input  wire logic [31:0] i_blk_dst,
    input  wire logic [31:0] i_blk_cnt,
    input  wire logic        i_int_req,
    input  wire logic [31:0] i_mem_rdata,
    input  wire logic        i_mem_ack,
    input  wire logic        i_mem_fault,
    output logic             o_busy,
    output logic             o_done,
    output logic [31:0]      o_result,
    output logic             o_result_wr,
    output logic             o_flag_n,
    output logic             o_flag_z,
    output logic             o_flag_c,
    output logic             o_flag_v,
    output logic             o_flags_wr,
    output logic             o_exc_illegal,
    output logic             o_exc_zero_div,
    output logic             o_exc_overflow,
    output logic             o_mem_rd,
    output logic             o_mem_wr,
    output logic [31:0]      o_mem_addr,
    output logic [31:0]      o_mem_wdata,
    output logic [31:0]      o_blk_src,
    output logic [31:0]      o_blk_dst,
    output logic [31:0]      o_blk_cnt,
    output logic             o_blk_wr,
    output logic             o_int_hold,
    output logic             o_blk_yield,
    output logic             o_blk_fault
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Extend the low bits of a value of the given size to 64 bits
    function automatic logic [63:0] extend(input logic [63:0] v, input logic [1:0] sz,
                                           input logic sgn);
        logic [63:0] r;
        r = v;
        case (sz)
            SIZE_BYTE: r = {{56{sgn & v[BYTE_BITS-1]}}, v[BYTE_BITS-1:0]};
            SIZE_HALF: r = {{48{sgn & v[HALF_BITS-1]}}, v[HALF_BITS-1:0]};
            default:   r = {{32{sgn & v[WORD_BITS-1]}}, v[WORD_BITS-1:0]};
        endcase
        return r;
    endfunction : extend

    function automatic logic top_bit(input logic [31:0] v, input logic [1:0] sz);
        logic b;
        b = v[WORD_BITS-1];
        case (sz)
            SIZE_BYTE: b = v[BYTE_BITS-1];
            SIZE_HALF: b = v[HALF_BITS-1];
            default:   b = v[WORD_BITS-1];
        endcase
        return b;
    endfunction : top_bit

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_ff;
    logic rst_sync_ff;
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end
    wire logic nrst = rst_sync_ff;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire logic [7:0] op8       = i_opcode[7:0];
    wire logic       op_rem    = (op8 == OP_REM_BYTE_TWO_OP) || (op8 == OP_REM_HALF_TWO_OP)
                              || (op8 == OP_REM_WORD_TWO_OP) || (op8 == OP_REM_BYTE_THREE_OP)
                              || (op8 == OP_REM_HALF_THREE_OP)
                              || (op8 == OP_REM_WORD_THREE_OP);
    wire logic       op_mul    = (op8 == OP_PRODUCT_BYTE_TWO_OP)
                              || (op8 == OP_PRODUCT_HALF_TWO_OP)
                              || (op8 == OP_PRODUCT_WORD_TWO_OP)
                              || (op8 == OP_PRODUCT_BYTE_THREE_OP)
                              || (op8 == OP_PRODUCT_HALF_THREE_OP)
                              || (op8 == OP_PRODUCT_WORD_THREE_OP);
    wire logic       op_copy   = (op8 == OP_COPY_BYTE) || (op8 == OP_COPY_HALF)
                              || (op8 == OP_COPY_WORD);
    wire logic       op_lea    = (op8 == OP_LOAD_EFFECTIVE_ADDR);
    wire logic       is_blk    = (i_opcode == OP_BLOCK_WORD_COPY);
    wire logic       is_short  = (i_opcode[15:8] == 8'h00);
    wire logic       is_rem    = is_short && op_rem;
    wire logic       is_mul    = is_short && op_mul;
    wire logic       is_copy   = is_short && op_copy;
    wire logic       is_lea    = is_short && op_lea;
    // Low opcode bits pick the width: x7/xB byte, x6/xA half, x4/x8 word
    wire logic [1:0] op_size   = (op8[1:0] == 2'h3) ? SIZE_BYTE :
                                 (op8[1:0] == 2'h2) ? SIZE_HALF : SIZE_WORD;

    // ------------------------------------------------------------------
    // Arithmetic: dividend and multiplicand come from i_op_b, divisor from i_op_a
    // ------------------------------------------------------------------
    wire logic [63:0] a_ext     = extend({32'h0000_0000, i_op_a}, op_size, 1'b1);
    wire logic [63:0] b_ext     = extend({32'h0000_0000, i_op_b}, op_size, 1'b1);
    wire logic        div_zero  = (a_ext == 64'h0000_0000_0000_0000);
    wire logic [31:0] a_div     = div_zero ? 32'h0000_0001 : a_ext[31:0];
    wire logic [31:0] rem_raw   = 32'($signed(b_ext[31:0]) % $signed(a_div));
    wire logic [63:0] prod_raw  = 64'($signed(a_ext) * $signed(b_ext));
    wire logic [63:0] arith_raw = is_rem ? extend({32'h0000_0000, rem_raw}, SIZE_WORD, 1'b1)
                                         : prod_raw;
    wire logic [63:0] arith_fit = extend(arith_raw, i_dst_size, 1'b1);
    wire logic        arith_ovf = (arith_fit != arith_raw);

    // ------------------------------------------------------------------
    // Moves
    // ------------------------------------------------------------------
    // Source type chooses the extension, destination type chooses the cut
    wire logic [63:0] mov_raw  = extend({32'h0000_0000, i_op_a}, i_src_size,
                                        i_src_signed);
    wire logic [63:0] mov_fit  = extend(mov_raw, i_dst_size, i_dst_signed);
    wire logic        mov_ovf  = (mov_fit != mov_raw);
    wire logic        psw_move = is_copy && (op8 == OP_COPY_WORD)
                                 && (i_src_is_psw || i_dst_is_psw);

    // ------------------------------------------------------------------
    // Result selection
    // ------------------------------------------------------------------
    wire logic        illegal  = i_dst_immediate || (is_lea && i_src_no_ea);
    wire logic [31:0] sel_val  = is_lea  ? i_src_ea :
                                 is_copy ? mov_fit[31:0] : arith_fit[31:0];
    wire logic [1:0]  sel_size = is_lea ? SIZE_WORD : i_dst_size;
    wire logic [63:0] sel_ext  = extend({32'h0000_0000, sel_val}, sel_size, 1'b0);
    wire logic [31:0] sel_res  = sel_ext[31:0];
    wire logic        sel_v    = is_copy ? mov_ovf : (is_lea ? 1'b0 : arith_ovf);
    wire logic        alu_op   = is_rem || is_mul || is_copy || is_lea;
    wire logic        zdiv_exc = is_rem && div_zero && !illegal;
    wire logic        ovf_exc  = (is_rem || is_mul) && arith_ovf && !illegal
                                 && !zdiv_exc;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    exec_state_t state_ff;
    exec_state_t nxt_state;
    logic [31:0] data_ff;

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
                if (i_start && is_blk)
                    nxt_state = ST_BLK_CHK;
            ST_BLK_CHK:
                if ((o_blk_cnt == 32'h0000_0000) || i_int_req)
                    nxt_state = ST_IDLE;
                else
                    nxt_state = ST_BLK_RD;
            ST_BLK_RD:
                if (i_mem_fault)
                    nxt_state = ST_IDLE;
                else if (i_mem_ack)
                    nxt_state = ST_BLK_WR;
            ST_BLK_WR:
                if (i_mem_fault)
                    nxt_state = ST_IDLE;
                else if (i_mem_ack)
                    nxt_state = ST_BLK_UPD;
            ST_BLK_UPD:
                nxt_state = ST_BLK_CHK;
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    wire logic alu_go  = (state_ff == ST_IDLE) && i_start && alu_op;
    wire logic bad_go  = (state_ff == ST_IDLE) && i_start && !alu_op && !is_blk;
    wire logic blk_end = (state_ff == ST_BLK_CHK) && (nxt_state == ST_IDLE);
    wire logic blk_flt = ((state_ff == ST_BLK_RD) || (state_ff == ST_BLK_WR)) && i_mem_fault;
    wire logic nxt_rd  = (nxt_state == ST_BLK_RD);
    wire logic nxt_wr  = (nxt_state == ST_BLK_WR);

    always_ff @(posedge i_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_ff <= ST_IDLE;
            data_ff  <= 32'h0000_0000;
        end
        else
        begin
            state_ff <= nxt_state;
            if ((state_ff == ST_BLK_RD) && i_mem_ack)
                data_ff <= i_mem_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Single-cycle answers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            o_done         <= 1'b0;
            o_result       <= 32'h0000_0000;
            o_result_wr    <= 1'b0;
            o_flag_n       <= 1'b0;
            o_flag_z       <= 1'b0;
            o_flag_c       <= 1'b0;
            o_flag_v       <= 1'b0;
            o_flags_wr     <= 1'b0;
            o_exc_illegal  <= 1'b0;
            o_exc_zero_div <= 1'b0;
            o_exc_overflow <= 1'b0;
        end
        else
        begin
            o_done         <= alu_go || bad_go || blk_end || blk_flt;
            o_result       <= alu_go ? sel_res : 32'h0000_0000;
            o_result_wr    <= alu_go && !illegal && !zdiv_exc;
            o_flag_n       <= top_bit(sel_res, sel_size);
            o_flag_z       <= (sel_res == 32'h0000_0000);
            o_flag_c       <= 1'b0;
            o_flag_v       <= sel_v;
            // Block copy never touches flags, nor do status-word moves
            o_flags_wr     <= alu_go && !illegal && !zdiv_exc && !psw_move;
            o_exc_illegal  <= alu_go && illegal;
            o_exc_zero_div <= alu_go && zdiv_exc;
            o_exc_overflow <= alu_go && ovf_exc;
        end
    end

    // ------------------------------------------------------------------
    // Block copy datapath
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            o_busy      <= 1'b0;
            o_mem_rd    <= 1'b0;
            o_mem_wr    <= 1'b0;
            o_mem_addr  <= 32'h0000_0000;
            o_mem_wdata <= 32'h0000_0000;
            o_blk_src   <= 32'h0000_0000;
            o_blk_dst   <= 32'h0000_0000;
            o_blk_cnt   <= 32'h0000_0000;
            o_blk_wr    <= 1'b0;
            o_int_hold  <= 1'b0;
            o_blk_yield <= 1'b0;
            o_blk_fault <= 1'b0;
        end
        else
        begin
            o_busy      <= (nxt_state != ST_IDLE);
            o_mem_rd    <= nxt_rd;
            o_mem_wr    <= nxt_wr;
            o_mem_addr  <= nxt_wr ? o_blk_dst : o_blk_src;
            o_mem_wdata <= nxt_wr ? data_ff : 32'h0000_0000;
            if ((state_ff == ST_BLK_RD) && i_mem_ack)
                o_mem_wdata <= i_mem_rdata;
            // Interrupts are only open while idle or sitting on an iteration boundary
            o_int_hold  <= (nxt_state != ST_IDLE) && (nxt_state != ST_BLK_CHK);
            o_blk_yield <= blk_end && (o_blk_cnt != 32'h0000_0000);
            o_blk_fault <= blk_flt;
            o_blk_wr    <= (state_ff == ST_BLK_UPD);
            if ((state_ff == ST_IDLE) && i_start && is_blk)
            begin
                o_blk_src <= i_blk_src;
                o_blk_dst <= i_blk_dst;
                o_blk_cnt <= i_blk_cnt;
            end
            else if (state_ff == ST_BLK_UPD)
            begin
                // Pointers move only once the store has been acknowledged
                o_blk_src <= o_blk_src + BLK_ADDR_STEP;
                o_blk_dst <= o_blk_dst + BLK_ADDR_STEP;
                o_blk_cnt <= o_blk_cnt - BLK_COUNT_STEP;
            end
        end
    end
    // A second start while busy is ignored by the idle-only decode; a fault ends the copy.

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!nrst);

    sequence s_store_ack;
        (state_ff == ST_BLK_WR) && i_mem_ack && !i_mem_fault;
    endsequence

    sequence s_ptr_step;
        ##2 o_blk_wr && (o_blk_cnt == $past(o_blk_cnt, 2) - BLK_COUNT_STEP)
            && (o_blk_src == $past(o_blk_src, 2) + BLK_ADDR_STEP);
    endsequence

    chk_zero_div_exc: assert property (
        (i_start && (state_ff == ST_IDLE) && is_rem && div_zero && !illegal)
        |=> o_exc_zero_div && !o_result_wr)
        else $error("zero divisor did not raise zero-divide");

    chk_flag_c_clear: assert property (
        o_flags_wr |-> !o_flag_c && (o_flag_z == (o_result == 32'h0000_0000)))
        else $error("carry or zero flag wrong on flag write");

    chk_ovf_exc: assert property (
        (i_start && (state_ff == ST_IDLE) && is_mul && !illegal && arith_ovf)
        |=> o_exc_overflow && o_flag_v)
        else $error("truncated product without overflow exception");

    chk_illegal_dst: assert property (
        (i_start && (state_ff == ST_IDLE) && alu_op && i_dst_immediate)
        |=> o_exc_illegal && !o_result_wr && !o_flags_wr)
        else $error("immediate destination was written");

    chk_psw_flags: assert property (
        (i_start && (state_ff == ST_IDLE) && psw_move && !illegal)
        |=> o_done && o_result_wr && !o_flags_wr)
        else $error("status word move changed flags");

    chk_lea_result: assert property (
        (i_start && (state_ff == ST_IDLE) && is_lea && !illegal)
        |=> o_result_wr && (o_result == $past(i_src_ea)) && !o_flag_v)
        else $error("move-address did not store the address");

    chk_blk_step: assert property (
        s_store_ack |-> s_ptr_step)
        else $error("block iteration step wrong");

    chk_blk_end: assert property (
        ((state_ff == ST_BLK_CHK) && (o_blk_cnt == 32'h0000_0000))
        |=> (state_ff == ST_IDLE) && o_done && !o_flags_wr && !o_blk_yield)
        else $error("block copy did not end at zero count");

    chk_int_hold: assert property (
        (state_ff == ST_BLK_UPD) |-> o_int_hold ##1 !o_int_hold)
        else $error("interrupts not held over the update");

    chk_fault_keep: assert property (
        (((state_ff == ST_BLK_RD) || (state_ff == ST_BLK_WR)) && i_mem_fault)
        |=> o_blk_fault && $stable(o_blk_cnt) && !o_blk_wr)
        else $error("faulted iteration updated pointers");

endmodule : rem_mul_move_exec

`default_nettype wire

// *** tb/op_memory_model.sv ***
// Word memory on the far side of the block's bus, answering promptly or slowly
`timescale 1ns/1ps
`default_nettype none
module op_memory_model (
    input  wire logic        i_clk,
    input  wire logic        i_rd,
    input  wire logic        i_wr,
    input  wire logic [31:0] i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_fault_en,
    input  wire logic [31:0] i_fault_addr,
    output logic [31:0]      o_rdata,
    output logic             o_ack,
    output logic             o_fault
);
    logic [31:0] mem [0:255];
    logic [1:0]  wt = 2'h0;
    logic        slow = 1'b0;
    wire logic   ask = (i_rd | i_wr) & ~o_ack & ~o_fault;
    wire logic   hit = i_fault_en & (i_addr == i_fault_addr);
    initial {o_rdata, o_ack, o_fault} = '0;
    always @(posedge i_clk)
    begin
        o_rdata <= ~o_rdata; // Released data never keeps showing the last word
        wt      <= ask ? wt + 2'h1 : 2'h0;
        o_ack   <= ask & (wt == {slow, slow}) & ~hit;
        o_fault <= ask & (wt == {slow, slow}) & hit;
        if (ask & (wt == {slow, slow}))
        begin
            slow <= ~slow; // Alternate prompt and four-cycle answers
            if (i_rd)
                o_rdata <= mem[i_addr[9:2]];
            else if (~hit)
                mem[i_addr[9:2]] <= i_wdata;
        end
    end
endmodule : op_memory_model
`default_nettype wire

// *** tb/tb_modulo_move_multiply_exec.sv ***
// Self-checking bench for the remainder, multiply and move execution block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch %0t: got %h exp %h", $time, g, e); end end
module tb_modulo_move_multiply_exec;
    logic        i_clk = 0, i_nrst = 0, i_start = 0, i_int_req = 0, f_en = 0;
    logic [15:0] i_opcode = 0;
    logic [31:0] i_op_a = 0, i_op_b = 0, i_blk_src = 0, i_blk_dst = 0, i_blk_cnt = 0;
    logic [31:0] l_src, l_dst, l_cnt, a, b, rng = 32'h62C3;
    logic [7:0]  ctl = 0, op;
    logic [7:0]  ops [12] = '{8'hA7, 8'hA6, 8'hA4, 8'hE7, 8'hE6, 8'hE4,
                              8'hAB, 8'hAA, 8'hA8, 8'hEB, 8'hEA, 8'hE8};
    logic [1:0]  i_dst_size = 0;
    logic [42:0] q [$], ev;
    int          n_errors = 0, check_count = 0, w;
    wire logic [31:0] o_result, o_mem_addr, o_mem_wdata, o_blk_src, o_blk_dst, o_blk_cnt;
    wire logic [31:0] i_mem_rdata;
    wire logic o_done, o_result_wr, o_flag_n, o_flag_z, o_flag_c, o_flag_v, o_flags_wr;
    wire logic o_exc_illegal, o_exc_zero_div, o_exc_overflow, o_mem_rd, o_mem_wr, o_blk_wr;
    wire logic o_int_hold, o_blk_yield, o_blk_fault, i_mem_ack, i_mem_fault, o_busy;
    wire logic [42:0] obs = {o_result_wr, o_result & {32{o_result_wr}}, o_flags_wr,
        {o_flag_n, o_flag_z, o_flag_c, o_flag_v} & {4{o_flags_wr}}, o_exc_illegal,
        o_exc_zero_div, o_exc_overflow, o_blk_yield, o_blk_fault};
    rem_mul_move_exec i_dut (.*, .i_src_ea(i_op_a), .i_src_size(ctl[7:6]),
        .i_src_signed(ctl[5]), .i_dst_signed(ctl[4]), .i_dst_immediate(ctl[3]),
        .i_src_no_ea(ctl[2]), .i_src_is_psw(ctl[1]), .i_dst_is_psw(ctl[0]));
    op_memory_model i_mem (.i_clk(i_clk), .i_rd(o_mem_rd), .i_wr(o_mem_wr),
        .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .i_fault_en(f_en),
        .i_fault_addr(32'h104), .o_rdata(i_mem_rdata), .o_ack(i_mem_ack), .o_fault(i_mem_fault));
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : xs
    function automatic longint sx(logic [31:0] v, int n);
        return n == 8 ? longint'($signed(v[7:0])) : n == 16 ? longint'($signed(v[15:0]))
            : longint'($signed(v));
    endfunction : sx
    // Signed arithmetic at operand width; a result that does not fit is truncated
    function automatic logic [42:0] alu_exp(logic [7:0] o, logic [31:0] s, d, int n);
        longint r;
        logic [31:0] t;
        r = o[3] ? sx(d, n) * sx(s, n) : sx(d, n) % sx(s, n);
        t = 32'(r & ((64'h1 << n) - 1));
        return {1'b1, t, 1'b1, t[n-1], t == 0, 1'b0, sx(t, n) != r, 2'h0, sx(t, n) != r, 2'h0};
    endfunction : alu_exp
    task automatic issue(logic [15:0] o, logic [31:0] s, d, logic [1:0] z, logic [7:0] c,
                         logic [42:0] e);
        @(posedge i_clk);
        {i_opcode, i_op_a, i_op_b, i_dst_size, ctl} <= {o, s, d, z, c};
        i_start <= 1'b1;
        q.push_back(e);
    endtask : issue
    task automatic drain;
        @(posedge i_clk);
        i_start <= 1'b0;
        for (int k = 0; k < 3000 && q.size() != 0; k++)
            @(posedge i_clk);
        if (q.size() != 0)
        begin
            n_errors++;
            $display("mismatch %0t: no answer in time", $time);
        end
    endtask : drain
    task automatic blk(logic [31:0] s, d, c, logic [42:0] e);
        {i_blk_src, i_blk_dst, i_blk_cnt} <= {s, d, c};
        issue(16'h3019, 32'h0, 32'h0, 2'h2, 8'h00, e);
        drain;
    endtask : blk
    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up
    initial forever #5 i_clk = ~i_clk;
    always @(negedge i_clk)
    begin
        if ((o_mem_rd | o_mem_wr) === 1'b1)
            `CHK({o_int_hold, o_busy}, 2'b11)
        if (o_blk_wr === 1'b1)
            {l_src, l_dst, l_cnt} = {o_blk_src, o_blk_dst, o_blk_cnt};
        if (o_done === 1'b1)
        begin
            ev = q.pop_front();
            `CHK(o_busy, 1'b0)
            `CHK(obs, ev)
        end
    end
    initial
    begin
        #200000;
        n_errors++;
        wrap_up;
    end
    initial
    begin
        repeat (8) @(posedge i_clk);
        i_nrst <= 1'b1;
        repeat (4) @(posedge i_clk);
        // Starts follow each other with no gap; shifted randoms mix fitting and overflowing
        for (int i = 0; i < 36; i++)
        begin
            op = ops[i % 12];
            w = op[1:0] == 2'h3 ? 8 : op[1:0] == 2'h2 ? 16 : 32;
            a = 32'(sx(xs() >> (xs() % 32), w));
            b = 32'(sx(xs() >> (xs() % 32), w));
            if (a == 0)
                a = 32'h3;
            issue({8'h0, op}, a, b, 2'(w / 16), 8'h00, alu_exp(op, a, b, w));
        end
        issue(16'hA4, 32'h0, 32'h5, 2'h2, 8'h00, {38'h0, 5'h08});
        issue(16'hEB, 32'h2, 32'h3, 2'h0, 8'h08, {38'h0, 5'h10});
        issue(16'h87, 32'h80, 32'h0, 2'h2, 8'h30, {1'b1, 32'hFFFFFF80, 1'b1, 9'h100});
        issue(16'h86, 32'h8000, 32'h0, 2'h2, 8'h50, {1'b1, 32'h8000, 1'b1, 9'h0});
        issue(16'h84, 32'h100, 32'h0, 2'h0, 8'h90, {1'b1, 32'h0, 1'b1, 9'hA0});
        issue(16'h84, 32'h0, 32'h0, 2'h2, 8'h81, {1'b1, 32'h0, 10'h0});
        issue(16'h04, 32'h80001014, 32'h0, 2'h2, 8'h00, {1'b1, 32'h80001014, 1'b1, 9'h100});
        issue(16'h04, 32'h1014, 32'h0, 2'h2, 8'h04, {38'h0, 5'h10});
        issue(16'h86, 32'h12345678, 32'h0, 2'h1, 8'h40, {1'b1, 32'h5678, 1'b1, 9'h0});
        issue(16'h3018, 32'h0, 32'h0, 2'h2, 8'h00, 43'h0);
        drain;
        i_mem.mem[64] = 32'h5;
        i_mem.mem[65] = 32'h10;
        i_mem.mem[66] = 32'h20;
        blk(32'h100, 32'h200, 32'h3, 43'h0);
        `CHK({l_src, l_dst, l_cnt, i_mem.mem[130]}, {32'h10C, 32'h20C, 32'h0, 32'h20})
        blk(32'h100, 32'h200, 32'h0, 43'h0);
        i_int_req <= 1'b1;
        blk(32'h100, 32'h400, 32'h2, 43'h2);
        i_int_req <= 1'b0;
        f_en <= 1'b1;
        blk(32'h100, 32'h300, 32'h2, 43'h1);
        `CHK({l_src, l_dst, l_cnt}, {32'h104, 32'h304, 32'h1})
        f_en <= 1'b0;
        blk(l_src, l_dst, l_cnt, 43'h0);
        `CHK({i_mem.mem[192], i_mem.mem[193]}, {32'h5, 32'h10})
        wrap_up;
    end
endmodule : tb_modulo_move_multiply_exec
`default_nettype wire
